//--- dv/host_model.sv
// host-side model issuing register accesses and receive holding reads
`timescale 1ns/1ps
module host_model
    import uart_lsmc_pkg::*;
(
    input wire logic clk_sys_i,
    output reg_sel_t reg_sel_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic feature_write_en_o,
    output logic rhr_rd_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic [7:0] rhr_data_i
);
    initial begin
        reg_sel_o = SEL_LINE_STATUS;
        {reg_rd_o, reg_wr_o, feature_write_en_o, rhr_rd_o} = 4'h0;
        reg_wdata_o = 8'hA5;
    end

    task automatic rd(input reg_sel_t s, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_sel_o <= s;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        #1 d = reg_rdata_i;
    endtask

    // enable is left as given; each later write drives its own value with its strobe
    task automatic wr(input reg_sel_t s, input logic [7:0] d, input logic fwe);
        @(posedge clk_sys_i);
        reg_sel_o <= s;
        reg_wdata_o <= d;
        feature_write_en_o <= fwe;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask

    // callers read line status first so tags pair with this character
    task automatic receive_holding_reg(output logic [7:0] d);
        @(posedge clk_sys_i);
        rhr_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rhr_rd_o <= 1'b0;
        #1 d = rhr_data_i;
    endtask
endmodule

//--- dv/uart_line_status_modem_ctrl_tb.sv
// self-checking bench for the line status and upper modem control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module uart_line_status_modem_ctrl_tb;
    import uart_lsmc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    reg_sel_t sel;
    logic rd, wr, fwe, rhr_rd, tx_resume, baud_tick, irda, xon_any;
    logic [7:0] wdata, rdata, rhr_data;
    logic rx_push = 1'b0, rx_brk = 1'b0, rx_fe = 1'b0, rx_pe = 1'b0;
    logic thr_e = 1'b1, tsr_e = 1'b1, halted = 1'b0, ovr = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic [7:0] d;
    logic [7:0] mc = 8'h00;
    logic [10:0] q[$];
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int k;
    int r;

    always #10 clk_sys_i = ~clk_sys_i;

    host_model u_host_model (.clk_sys_i(clk_sys_i), .reg_sel_o(sel), .reg_rd_o(rd), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .feature_write_en_o(fwe), .rhr_rd_o(rhr_rd), .reg_rdata_i(rdata),
        .rhr_data_i(rhr_data));

    uart_line_status_modem_ctrl u_uart_line_status_modem_ctrl (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reg_sel_i(sel), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .feature_write_en_i(fwe), .rx_push_i(rx_push), .rx_data_i(rx_data), .rx_break_i(rx_brk),
        .rx_stop_bad_i(rx_fe), .rx_parity_bad_i(rx_pe), .rhr_rd_i(rhr_rd), .rhr_data_o(rhr_data),
        .thr_empty_i(thr_e), .tsr_empty_i(tsr_e), .tx_halted_i(halted), .tx_resume_o(tx_resume),
        .baud_tick_o(baud_tick), .irda_mode_o(irda), .xon_any_o(xon_any));

    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    // model entry is {break, framing, parity, data}
    function automatic logic [7:0] exp_ls();
        logic e = 1'b0;
        foreach (q[i]) e |= |q[i][10:8];
        return {e, thr_e & tsr_e, thr_e, (q.size() > 0) ? q[0][10:8] : 3'b000, ovr, q.size() > 0};
    endfunction

    task automatic push(input logic [7:0] dt, input logic [2:0] t);
        @(posedge clk_sys_i);
        rx_push <= 1'b1;
        rx_data <= dt;
        {rx_brk, rx_fe, rx_pe} <= t;
        @(posedge clk_sys_i);
        rx_push <= 1'b0;
        rx_data <= ~dt;
        {rx_brk, rx_fe, rx_pe} <= ~t;
        if (q.size() == 64) ovr = 1'b1;
        else q.push_back({t, t[2] ? 8'h00 : dt});
    endtask

    task automatic chk_ls();
        u_host_model.rd(SEL_LINE_STATUS, d);
        `CHK(d, exp_ls())
        ovr = 1'b0;
    endtask

    task automatic drain();
        while (q.size() > 0) begin
            chk_ls();
            u_host_model.receive_holding_reg(d);
            `CHK(d, q[0][7:0])
            void'(q.pop_front());
        end
        chk_ls();
    endtask

    task automatic chk_ticks(input logic [7:0] n_exp);
        logic [7:0] n = 8'h00;
        repeat (2) @(posedge clk_sys_i);
        repeat (40) begin
            @(posedge clk_sys_i);
            #1 n += baud_tick;
        end
        `CHK(n, n_exp)
    endtask

    // bits 7:5 and 2 move only with the feature enable; bit 3 always reads zero
    task automatic chk_mc(input logic [7:0] v, input logic f);
        mc = f ? v : ((mc & 8'hE4) | (v & 8'h1B));
        mc[3] = 1'b0;
        u_host_model.wr(SEL_MODEM_CONTROL, v, f);
        u_host_model.rd(SEL_MODEM_CONTROL, d);
        `CHK(d, mc)
        `CHK(irda, mc[6])
        `CHK(xon_any, mc[5])
        chk_ticks(mc[7] ? 8'h0A : 8'h28);
    endtask

    // the resume pulse stands for one cycle only, so it is looked at right after the push edge
    task automatic chk_resume(input logic [7:0] dt, input logic [2:0] t);
        @(posedge clk_sys_i);
        halted <= 1'b1;
        push(dt, t);
        #1;
        `CHK(tx_resume, mc[5])
        @(posedge clk_sys_i);
        halted <= 1'b0;
        #1;
        `CHK(tx_resume, 1'b0)
    endtask

    initial begin
        void'($urandom(32'h711E9A64));
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        `CHK({rdata, rhr_data, irda, xon_any, tx_resume}, 19'h00000)
        chk_ls();
        u_host_model.receive_holding_reg(d);
        `CHK(d, 8'h00)
        chk_ticks(8'h28);
        chk_mc(8'hFF, 1'b0);
        chk_mc(8'hE5, 1'b1);
        chk_mc(8'h1A, 1'b0);
        chk_resume(8'h41, 3'b000);
        chk_mc(8'h00, 1'b1);
        chk_resume(8'h42, 3'b010);
        drain();
        push(8'h5A, 3'b100);
        push(8'h33, 3'b000);
        drain();
        for (k = 0; k < 300; k++) begin
            r = $urandom;
            @(posedge clk_sys_i);
            thr_e <= r[8];
            tsr_e <= r[9];
            if (r[1:0] != 2'h0) begin
                push(r[17:10], r[4:2]);
            end else if (q.size() > 0) begin
                chk_ls();
                u_host_model.receive_holding_reg(d);
                `CHK(d, q[0][7:0])
                void'(q.pop_front());
            end
            if (r[7:5] == 3'h0) begin
                chk_ls();
            end
        end
        drain();
        for (k = 0; k < 65; k++) begin
            push(k[7:0], 3'b000);
        end
        chk_ls();
        chk_ls();
        drain();
        push(8'h77, 3'b001);
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        q.delete();
        mc = 8'h00;
        ovr = 1'b0;
        @(posedge clk_sys_i);
        #1;
        `CHK({rdata, rhr_data, irda, xon_any, tx_resume}, 19'h00000)
        chk_ls();
        chk_mc(8'h04, 1'b0);
        stop_test();
    end
endmodule

//--- hdl/rx_err_fifo.sv
// receive fifo keeping break, framing and parity tags with each character
`timescale 1ns/1ps
`include "uart_lsmc_consts.svh"
module rx_err_fifo
    import uart_lsmc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic push_brk_i,
    input wire logic push_fe_i,
    input wire logic push_pe_i,
    input wire logic pop_i,
    output logic [7:0] head_data_o,
    output logic head_brk_o,
    output logic head_fe_o,
    output logic head_pe_o,
    output logic empty_o,
    output logic full_o,
    output logic err_present_o
);
    rx_entry_t mem [`FIFO_DEPTH];
    rx_entry_t head;
    logic [`FIFO_PTR_W-1:0] wr_ptr;
    logic [`FIFO_PTR_W-1:0] rd_ptr;
    logic [`FIFO_PTR_W:0] count;
    logic [`FIFO_PTR_W:0] err_cnt;
    logic do_push;
    logic do_pop;
    logic push_err;
    logic head_err;

    assign head = mem[rd_ptr];
    assign empty_o = (count == '0);
    assign full_o = (count == `FIFO_FULL);
    assign do_pop = pop_i && !empty_o;
    // a push into a full fifo is only taken when a pop frees a slot this cycle
    assign do_push = push_i && (!full_o || do_pop);
    assign push_err = push_brk_i || push_fe_i || push_pe_i;
    assign head_err = head.brk || head.fe || head.pe;
    assign head_data_o = head.data;
    assign head_brk_o = head.brk;
    assign head_fe_o = head.fe;
    assign head_pe_o = head.pe;
    assign err_present_o = (err_cnt != '0);

    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem[wr_ptr] <= '{brk: push_brk_i, fe: push_fe_i, pe: push_pe_i, data: push_data_i};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end

    // counting errored entries avoids scanning all 64 slots for the summary flag
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            err_cnt <= '0;
        end else if ((do_push && push_err) && !(do_pop && head_err)) begin
            err_cnt <= err_cnt + 1'b1;
        end else if ((do_pop && head_err) && !(do_push && push_err)) begin
            err_cnt <= err_cnt - 1'b1;
        end
    end
endmodule

//--- hdl/uart_line_status_modem_ctrl.sv
// line status reporting and upper modem control of a single-channel uart
`timescale 1ns/1ps
`include "uart_lsmc_consts.svh"
module uart_line_status_modem_ctrl
    import uart_lsmc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire reg_sel_t reg_sel_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic feature_write_en_i,
    input wire logic rx_push_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_break_i,
    input wire logic rx_stop_bad_i,
    input wire logic rx_parity_bad_i,
    input wire logic rhr_rd_i,
    output logic [7:0] rhr_data_o,
    input wire logic thr_empty_i,
    input wire logic tsr_empty_i,
    input wire logic tx_halted_i,
    output logic tx_resume_o,
    output logic baud_tick_o,
    output logic irda_mode_o,
    output logic xon_any_o
);
    logic [7:0] modem_control;
    logic [7:0] line_status;
    logic overrun;
    logic [1:0] prescale_cnt;
    logic [7:0] push_data;
    logic [7:0] head_data;
    logic head_brk;
    logic head_fe;
    logic head_pe;
    logic fifo_empty;
    logic fifo_full;
    logic fifo_err;
    logic overrun_set;
    logic ls_read;
    logic mc_write;
    logic [7:0] next_modem_control;

    // a break always lands as a zero character regardless of the sampled bits
    assign push_data = rx_break_i ? `BREAK_CHAR : rx_data_i;

    rx_err_fifo u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .push_i(rx_push_i),
        .push_data_i(push_data),
        .push_brk_i(rx_break_i),
        .push_fe_i(rx_stop_bad_i),
        .push_pe_i(rx_parity_bad_i),
        .pop_i(rhr_rd_i),
        .head_data_o(head_data),
        .head_brk_o(head_brk),
        .head_fe_o(head_fe),
        .head_pe_o(head_pe),
        .empty_o(fifo_empty),
        .full_o(fifo_full),
        .err_present_o(fifo_err)
    );

    assign ls_read = reg_rd_i && (reg_sel_i == SEL_LINE_STATUS);
    assign mc_write = reg_wr_i && (reg_sel_i == SEL_MODEM_CONTROL);
    assign overrun_set = rx_push_i && fifo_full && !rhr_rd_i;

    always_comb begin
        line_status = 8'h00;
        line_status[`LS_FIFO_ERR] = fifo_err;
        line_status[`LS_TX_EMPTY] = thr_empty_i && tsr_empty_i;
        line_status[`LS_THR_EMPTY] = thr_empty_i;
        // tags of the next character to be read; nothing shows while empty
        line_status[`LS_BREAK] = head_brk && !fifo_empty;
        line_status[`LS_FRAMING] = head_fe && !fifo_empty;
        line_status[`LS_PARITY] = head_pe && !fifo_empty;
        line_status[`LS_OVERRUN] = overrun;
        line_status[`LS_DATA_READY] = !fifo_empty;
    end

    // protected bits keep their old value unless the feature write enable is set
    always_comb begin
        next_modem_control = modem_control;
        if (mc_write) begin
            if (feature_write_en_i) begin
                next_modem_control = reg_wdata_i;
            end else begin
                next_modem_control = (modem_control & `MC_PROTECTED_MASK) |
                                     (reg_wdata_i & ~`MC_PROTECTED_MASK);
            end
            next_modem_control[`MC_RESERVED] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            modem_control <= `MC_RESET;
        end else begin
            modem_control <= next_modem_control;
        end
    end

    // a character lost in the same cycle as the status read still leaves the flag set
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            overrun <= 1'b0;
        end else if (overrun_set) begin
            overrun <= 1'b1;
        end else if (ls_read) begin
            overrun <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= (reg_sel_i == SEL_LINE_STATUS) ? line_status : modem_control;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rhr_data_o <= 8'h00;
        end else if (rhr_rd_i) begin
            rhr_data_o <= fifo_empty ? 8'h00 : head_data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prescale_cnt <= 2'h0;
            baud_tick_o <= 1'b0;
        end else begin
            prescale_cnt <= prescale_cnt + 1'b1;
            baud_tick_o <= !modem_control[`MC_PRESCALE] || (prescale_cnt == `PRESCALE_LAST);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            irda_mode_o <= 1'b0;
            xon_any_o <= 1'b0;
        end else begin
            irda_mode_o <= next_modem_control[`MC_IRDA];
            xon_any_o <= next_modem_control[`MC_XON_ANY];
        end
    end

    // any received character, errored or not, counts as a resume trigger
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tx_resume_o <= 1'b0;
        end else begin
            tx_resume_o <= xon_any_o && tx_halted_i && rx_push_i;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    property p_err_summary;
        rx_push_i && !fifo_full && (rx_break_i || rx_stop_bad_i || rx_parity_bad_i) |=> fifo_err;
    endproperty
    a_err_summary: assert property (p_err_summary) else $error("fifo error summary not set");

    property p_err_clears;
        fifo_empty |-> !fifo_err;
    endproperty
    a_err_clears: assert property (p_err_clears) else $error("fifo error summary set while empty");

    property p_tx_empty;
        ls_read |=> reg_rdata_o[`LS_TX_EMPTY] == $past(thr_empty_i && tsr_empty_i);
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("transmitter empty bit wrong");

    property p_thr_empty;
        ls_read |=> reg_rdata_o[`LS_THR_EMPTY] == $past(thr_empty_i);
    endproperty
    a_thr_empty: assert property (p_thr_empty) else $error("holding empty bit wrong");

    property p_break_char;
        ls_read && head_brk && !fifo_empty |=> reg_rdata_o[`LS_BREAK] && reg_rdata_o[`LS_DATA_READY];
    endproperty
    a_break_char: assert property (p_break_char) else $error("break not reported for head");

    property p_break_zero;
        rhr_rd_i && head_brk && !fifo_empty |=> rhr_data_o == 8'h00;
    endproperty
    a_break_zero: assert property (p_break_zero) else $error("break character not zero");

    property p_framing;
        ls_read |=> reg_rdata_o[`LS_FRAMING] == $past(head_fe && !fifo_empty);
    endproperty
    a_framing: assert property (p_framing) else $error("framing bit not from head");

    property p_parity;
        ls_read |=> reg_rdata_o[`LS_PARITY] == $past(head_pe && !fifo_empty);
    endproperty
    a_parity: assert property (p_parity) else $error("parity bit not from head");

    property p_overrun;
        overrun_set |=> overrun ##1 (overrun || $past(ls_read));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not held");

    property p_data_ready;
        ls_read |=> reg_rdata_o[`LS_DATA_READY] == !$past(fifo_empty);
    endproperty
    a_data_ready: assert property (p_data_ready) else $error("data ready bit wrong");

    property p_pairing;
        rhr_rd_i && !fifo_empty |=> rhr_data_o == $past(head_data);
    endproperty
    a_pairing: assert property (p_pairing) else $error("read data not head character");

    property p_undivided;
        !modem_control[`MC_PRESCALE] |=> baud_tick_o;
    endproperty
    a_undivided: assert property (p_undivided) else $error("undivided tick missing");

    property p_divided;
        modem_control[`MC_PRESCALE] && $stable(modem_control) && baud_tick_o |=> !baud_tick_o;
    endproperty
    a_divided: assert property (p_divided) else $error("divide by four ticks too fast");

    property p_irda;
        mc_write && feature_write_en_i |=> irda_mode_o == $past(reg_wdata_i[`MC_IRDA]);
    endproperty
    a_irda: assert property (p_irda) else $error("infrared select not taken");

    property p_xon_any;
        mc_write && feature_write_en_i |=> xon_any_o == $past(reg_wdata_i[`MC_XON_ANY]);
    endproperty
    a_xon_any: assert property (p_xon_any) else $error("resume option not taken");

    property p_protect;
        mc_write && !feature_write_en_i |=> modem_control[7:5] == $past(modem_control[7:5]);
    endproperty
    a_protect: assert property (p_protect) else $error("protected bits changed");

    property p_overrun_clear;
        ls_read && !overrun_set |=> !overrun;
    endproperty
    a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

    property p_resume;
        rx_push_i && tx_halted_i |=> tx_resume_o == $past(xon_any_o);
    endproperty
    a_resume: assert property (p_resume) else $error("resume pulse wrong");
endmodule

//--- hdl/uart_lsmc_consts.svh
// constants for the uart line status and upper modem control block
// Summary of operation
// - fifo error flag while any errored character stored
// - transmitter empty only when holding and shift empty
// - holding empty flag lets host write 64 characters
// - full-frame low input stores 00h with break
// - framing error tag shown for head character
// - parity error tag shown for head character
// - overrun flag set when character lost, reset zero
// - data ready while receive fifo holds a character
// - error tags travel with characters; read status first
// - prescaler bit selects input clock divide one or four
// - infrared select bit switches serial encoding mode
// - resume-on-any-character option follows its control bit
// - upper control bits writable only with feature enable
`ifndef UART_LSMC_CONSTS_SVH
`define UART_LSMC_CONSTS_SVH

// line status bit positions
`define LS_FIFO_ERR 7
`define LS_TX_EMPTY 6
`define LS_THR_EMPTY 5
`define LS_BREAK 4
`define LS_FRAMING 3
`define LS_PARITY 2
`define LS_OVERRUN 1
`define LS_DATA_READY 0

// modem control bit positions
`define MC_PRESCALE 7
`define MC_IRDA 6
`define MC_XON_ANY 5
`define MC_LOOPBACK 4
`define MC_RESERVED 3
`define MC_TCR_TLR 2
`define MC_RTS 1
`define MC_DTR 0

`define MC_RESET 8'h00
`define MC_PROTECTED_MASK 8'hE4
`define BREAK_CHAR 8'h00

// receive fifo shape
`define FIFO_DEPTH 64
`define FIFO_PTR_W 6
`define FIFO_FULL 7'h40

// divide-by-four prescaler terminal count
`define PRESCALE_LAST 2'h3

`endif

//--- hdl/uart_lsmc_pkg.sv
// types shared by the uart line status and modem control block
package uart_lsmc_pkg;
    typedef enum logic {SEL_LINE_STATUS, SEL_MODEM_CONTROL} reg_sel_t;

    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } rx_entry_t;
endpackage
